//--- design/phy_led_select_and_crossover_ctrl.sv
// led source selection and mdi/pair_crossover_state crossover control with axi4-lite
`timescale 1ns/1ps

// Overview of operation
// - codes 0-4: link, activity, tx, rx, collision
// - codes 5-8: speeds, duplex, link with blink
// - second selector 7:4 reset 1, first 3:0
// - parallel detect allows switching, partner negotiating
// - auto enable bit turns switching on, off
// - pair bit shows crossed or straight state
// - pair bit read-only while auto enabled
// - pair bit write forces state when disabled
// - done flag set once sequence finished
// - seed bits steer attempts 9,8,5,4
// - zero seed replaced by pattern 0101
module phy_led_select_and_crossover_ctrl #(
    parameter int SLOT_CYCLES  = phy_led_xo_pkg::SLOT_CYCLES,
    parameter int BLINK_CYCLES = phy_led_xo_pkg::BLINK_CYCLES
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    // axi4-lite slave
    input  wire logic [31:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [31:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // phy status conditions
    input  wire logic        i_link_good,
    input  wire logic        i_rx_activity,
    input  wire logic        i_tx_activity,
    input  wire logic        i_collision,
    input  wire logic        i_speed_100,
    input  wire logic        i_full_duplex,
    input  wire logic        i_local_aneg_enable,
    input  wire logic        i_partner_aneg_seen,
    input  wire logic        i_signal_detect,
    // outputs
    output logic             o_first_led,
    output logic             o_second_led,
    output logic             o_pair_crossover_state
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic        aw_hold;       // write address captured
        logic [31:0] aw_addr;       // captured write address
        logic        w_hold;        // write data captured
        logic [31:0] w_data;        // captured write data
        logic [3:0]  w_strb;        // captured byte enables
        logic        bvalid;        // write response pending
        logic [1:0]  bresp;         // write response code
        logic        rvalid;        // read data pending
        logic [31:0] rdata;         // read data
        logic [1:0]  rresp;         // read response code
        logic [15:0] led_sel;       // led_source_select contents
        logic        pd_en;         // parallel_detect_enable
        logic        auto_en;       // auto_crossover_enable
        logic        forced_state;  // software pair setting
        logic [3:0]  seed;          // crossover_seed
        logic        pair_state;    // automatic pair result
        logic        seq_done;      // crossover_sequence_done
        logic [3:0]  attempt;       // switching attempt number
        logic [31:0] slot_cnt;      // cycles within attempt
        logic [31:0] blink_cnt;     // blink half-period counter
        logic        blink_phase;   // blink on/off phase
        logic        first_led;     // registered led outputs
        logic        second_led;
    } state_s;

    state_s state_reg;   // registered state
    state_s state_next;  // next state

    logic   aw_take;     // address handshake
    logic   w_take;      // data handshake
    logic   ar_take;     // read address handshake
    logic   do_write;    // write performed this cycle
    logic   allowed;     // switching permitted now
    logic   pair_now;    // pair state as seen by software
    logic [3:0] eff_seed;  // seed actually used

    // ****************************************************************
    // decoding helpers
    // ****************************************************************
    // led level for one selector code
    function automatic logic led_level(input logic [3:0] sel,
                                       input logic blink);
        logic act;
        act = i_rx_activity | i_tx_activity;
        case (sel)
            phy_led_xo_pkg::LED_LINK_GOOD:   led_level = i_link_good;
            phy_led_xo_pkg::LED_ANY_ACT:     led_level = act;
            phy_led_xo_pkg::LED_TX_ACT:      led_level = i_tx_activity;
            phy_led_xo_pkg::LED_RX_ACT:      led_level = i_rx_activity;
            phy_led_xo_pkg::LED_COLLISION:   led_level = i_collision;
            phy_led_xo_pkg::LED_SPEED_100:   led_level = i_speed_100;
            phy_led_xo_pkg::LED_SPEED_10:    led_level = ~i_speed_100;
            phy_led_xo_pkg::LED_FULL_DUPLEX: led_level = i_full_duplex;
            // link on, activity turns it into a blink
            phy_led_xo_pkg::LED_LINK_BLINK:
                led_level = i_link_good & (~act | blink);
            default:                         led_level = 1'b0;
        endcase
    endfunction

    // pair choice for a given attempt number
    function automatic logic attempt_bit(input logic [3:0] n,
                                         input logic [3:0] s);
        case (n)
            4'h9:    attempt_bit = s[3];
            4'h8:    attempt_bit = s[2];
            4'h5:    attempt_bit = s[1];
            4'h4:    attempt_bit = s[0];
            default: attempt_bit = n[0];
        endcase
    endfunction

    // ****************************************************************
    // handshakes and derived levels
    // ****************************************************************
    assign o_awready = ~state_reg.aw_hold & ~state_reg.bvalid;
    assign o_wready  = ~state_reg.w_hold & ~state_reg.bvalid;
    assign o_arready = ~state_reg.rvalid;
    assign aw_take   = i_awvalid & o_awready;
    assign w_take    = i_wvalid & o_wready;
    assign ar_take   = i_arvalid & o_arready;
    assign do_write  = state_reg.aw_hold & state_reg.w_hold
                     & ~state_reg.bvalid;
    // zero seed falls back to the built-in pattern
    assign eff_seed  = (state_reg.seed == 4'h0) ?
                       phy_led_xo_pkg::DEFAULT_SEED :
                       state_reg.seed;
    // own negotiation, or parallel detect against a negotiating partner
    assign allowed   = state_reg.auto_en & (i_local_aneg_enable
                     | (state_reg.pd_en & i_partner_aneg_seen));
    assign pair_now  = state_reg.auto_en ? state_reg.pair_state
                     : state_reg.forced_state;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        // write channel capture
        if (aw_take) begin
            state_next.aw_hold = 1'b1;
            state_next.aw_addr = i_awaddr;
        end
        if (w_take) begin
            state_next.w_hold = 1'b1;
            state_next.w_data = i_wdata;
            state_next.w_strb = i_wstrb;
        end
        // register write once both halves are in
        if (do_write) begin
            state_next.aw_hold = 1'b0;
            state_next.w_hold  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = phy_led_xo_pkg::RESP_OKAY;
            if (state_reg.aw_addr ==
                phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR) begin
                if (state_reg.w_strb[0]) begin
                    state_next.led_sel[7:0] =
                        state_reg.w_data[7:0];
                end
                if (state_reg.w_strb[1]) begin
                    state_next.led_sel[15:8] = state_reg.w_data[15:8];
                end
            end else if (state_reg.aw_addr ==
                         phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR) begin
                if (state_reg.w_strb[0]) begin
                    state_next.pd_en = state_reg.w_data[
                        phy_led_xo_pkg::PD_ENABLE_BIT];
                    state_next.auto_en = state_reg.w_data[
                        phy_led_xo_pkg::AUTO_ENABLE_BIT];
                    state_next.seed = state_reg.w_data[
                        phy_led_xo_pkg::SEED_LSB +: 4];
                    // pair bit only writable while auto is off
                    if (!state_reg.auto_en) begin
                        state_next.forced_state = state_reg.w_data[
                            phy_led_xo_pkg::PAIR_STATE_BIT];
                    end
                end
            end else begin
                state_next.bresp = phy_led_xo_pkg::RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && i_bready) begin
            state_next.bvalid = 1'b0;
        end
        // read channel
        if (state_reg.rvalid && i_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = phy_led_xo_pkg::RESP_OKAY;
            state_next.rdata  = 32'h0000_0000;
            if (i_araddr == phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR) begin
                state_next.rdata[15:0] = state_reg.led_sel;
            end else if (i_araddr ==
                         phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR) begin
                state_next.rdata[phy_led_xo_pkg::PD_ENABLE_BIT] =
                    state_reg.pd_en;
                state_next.rdata[phy_led_xo_pkg::AUTO_ENABLE_BIT] =
                    state_reg.auto_en;
                state_next.rdata[phy_led_xo_pkg::PAIR_STATE_BIT] =
                    pair_now;
                state_next.rdata[phy_led_xo_pkg::SEQ_DONE_BIT] =
                    state_reg.seq_done;
                state_next.rdata[phy_led_xo_pkg::SEED_LSB +: 4] =
                    state_reg.seed;
            end else begin
                state_next.rresp = phy_led_xo_pkg::RESP_SLVERR;
            end
        end
        // crossover search sequence
        if (!state_reg.auto_en) begin
            // disabled: no sequence, flag low
            state_next.seq_done = 1'b0;
            state_next.attempt  = 4'h0;
            state_next.slot_cnt = 32'h0000_0000;
            state_next.pair_state = attempt_bit(4'h0, eff_seed);
        end else if (state_reg.seq_done) begin
            // signal lost: start over
            if (!i_signal_detect) begin
                state_next.seq_done = 1'b0;
                state_next.attempt  = 4'h0;
                state_next.slot_cnt = 32'h0000_0000;
            end
        end else if (allowed) begin
            if (i_signal_detect) begin
                state_next.seq_done = 1'b1;
            end else if (state_reg.slot_cnt ==
                         32'(SLOT_CYCLES - 1)) begin
                state_next.slot_cnt = 32'h0000_0000;
                state_next.attempt  = state_reg.attempt + 4'h1;
                state_next.pair_state = attempt_bit(
                    state_reg.attempt + 4'h1, eff_seed);
            end else begin
                state_next.slot_cnt = state_reg.slot_cnt + 32'h1;
            end
        end
        // blink timebase
        if (state_reg.blink_cnt == 32'(BLINK_CYCLES - 1)) begin
            state_next.blink_cnt   = 32'h0000_0000;
            state_next.blink_phase = ~state_reg.blink_phase;
        end else begin
            state_next.blink_cnt = state_reg.blink_cnt + 32'h1;
        end
        // led outputs
        state_next.first_led = led_level(
            state_reg.led_sel[phy_led_xo_pkg::FIRST_LED_LSB +: 4],
            state_reg.blink_phase);
        state_next.second_led = led_level(
            state_reg.led_sel[phy_led_xo_pkg::SECOND_LED_LSB +: 4],
            state_reg.blink_phase);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_reg <= '0;
            state_reg.led_sel <= phy_led_xo_pkg::LED_SEL_RESET;
            state_reg.pd_en <= phy_led_xo_pkg::PD_ENABLE_RESET;
            state_reg.auto_en <= phy_led_xo_pkg::AUTO_ENABLE_RESET;
            state_reg.forced_state <= phy_led_xo_pkg::PAIR_STATE_RESET;
            state_reg.seed <= phy_led_xo_pkg::SEED_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_bvalid = state_reg.bvalid;
    assign o_bresp  = state_reg.bresp;
    assign o_rvalid = state_reg.rvalid;
    assign o_rdata  = state_reg.rdata;
    assign o_rresp  = state_reg.rresp;
    assign o_first_led  = state_reg.first_led;
    assign o_second_led = state_reg.second_led;
    assign o_pair_crossover_state = pair_now;

    // ****************************************************************
    // assertions
    // ****************************************************************
    property p_led_collision;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.led_sel[3:0] == phy_led_xo_pkg::LED_COLLISION)
            |=> (o_first_led == $past(i_collision));
    endproperty
    a_led_collision: assert property (p_led_collision)
        else $error("first led does not follow collision");

    property p_led_undefined;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.led_sel[7:4] > 4'h8) |=> !o_second_led;
    endproperty
    a_led_undefined: assert property (p_led_undefined)
        else $error("second led lit on undefined code");

    property p_led_duplex;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.led_sel[7:4] == 4'h7) |=>
            (o_second_led == $past(i_full_duplex));
    endproperty
    a_led_duplex: assert property (p_led_duplex)
        else $error("second led does not follow duplex");

    property p_reset_sel;
        @(posedge i_sys_clk) $fell(i_reset)
            |-> (state_reg.led_sel == phy_led_xo_pkg::LED_SEL_RESET);
    endproperty
    a_reset_sel: assert property (p_reset_sel)
        else $error("led selectors wrong after reset");

    property p_pair_forced;
        @(posedge i_sys_clk) disable iff (i_reset)
        // a write with switching off and staying off forces the pair
        (do_write && !state_reg.auto_en && state_reg.w_strb[0]
            && !state_reg.w_data[phy_led_xo_pkg::AUTO_ENABLE_BIT]
            && state_reg.aw_addr == phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR)
            |=> (o_pair_crossover_state == $past(
                state_reg.w_data[phy_led_xo_pkg::PAIR_STATE_BIT]));
    endproperty
    a_pair_forced: assert property (p_pair_forced)
        else $error("pair state not forced value");

    property p_pair_ro;
        @(posedge i_sys_clk) disable iff (i_reset)
        (do_write && state_reg.auto_en) |=> $stable(state_reg.forced_state);
    endproperty
    a_pair_ro: assert property (p_pair_ro)
        else $error("pair bit written while auto on");

    property p_done_off;
        @(posedge i_sys_clk) disable iff (i_reset)
        !state_reg.auto_en |=> !state_reg.seq_done;
    endproperty
    a_done_off: assert property (p_done_off)
        else $error("done set with switching off");

    property p_no_switch;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.auto_en && !allowed && !state_reg.seq_done)
            |=> $stable(state_reg.attempt);
    endproperty
    a_no_switch: assert property (p_no_switch)
        else $error("switching while not permitted");

    property p_seed_zero;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.seed == 4'h0)
            |-> (eff_seed == phy_led_xo_pkg::DEFAULT_SEED);
    endproperty
    a_seed_zero: assert property (p_seed_zero)
        else $error("default seed not applied");

    property p_seed_attempt;
        @(posedge i_sys_clk) disable iff (i_reset)
        (state_reg.auto_en && $changed(state_reg.attempt)
            && state_reg.attempt == 4'h9)
            |-> (state_reg.pair_state == eff_seed[3]);
    endproperty
    a_seed_attempt: assert property (p_seed_attempt)
        else $error("attempt 9 ignores seed bit 3");

    c_write: cover property (@(posedge i_sys_clk) o_bvalid && i_bready);
    c_read: cover property (@(posedge i_sys_clk) o_rvalid && i_rready);
    c_done: cover property (@(posedge i_sys_clk) $rose(state_reg.seq_done));
    c_attempt: cover property (@(posedge i_sys_clk) state_reg.attempt == 4'h5);
endmodule

//--- inc/phy_led_xo_pkg.sv
// constants, layouts and reset values shared by the led/crossover block
package phy_led_xo_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [31:0] LED_SOURCE_SELECT_ADDR = 32'h0000_0000;
    localparam logic [31:0] CROSSOVER_CONTROL_ADDR = 32'h0000_0004;
    localparam logic [1:0]  RESP_OKAY              = 2'h0;
    localparam logic [1:0]  RESP_SLVERR            = 2'h2;
    // ****************************************************************
    // led_source_select fields
    // ****************************************************************
    localparam int          FIRST_LED_LSB      = 0;
    localparam int          SECOND_LED_LSB     = 4;
    localparam logic [15:0] LED_SEL_RESET      = 16'h0010;
    localparam logic [3:0]  LED_LINK_GOOD      = 4'h0;
    localparam logic [3:0]  LED_ANY_ACT        = 4'h1;
    localparam logic [3:0]  LED_TX_ACT         = 4'h2;
    localparam logic [3:0]  LED_RX_ACT         = 4'h3;
    localparam logic [3:0]  LED_COLLISION      = 4'h4;
    localparam logic [3:0]  LED_SPEED_100      = 4'h5;
    localparam logic [3:0]  LED_SPEED_10       = 4'h6;
    localparam logic [3:0]  LED_FULL_DUPLEX    = 4'h7;
    localparam logic [3:0]  LED_LINK_BLINK     = 4'h8;
    // ****************************************************************
    // crossover_control fields
    // ****************************************************************
    localparam int          PD_ENABLE_BIT      = 7;
    localparam int          AUTO_ENABLE_BIT    = 6;
    localparam int          PAIR_STATE_BIT     = 5;
    localparam int          SEQ_DONE_BIT       = 4;
    localparam int          SEED_LSB           = 0;
    localparam logic        PD_ENABLE_RESET    = 1'h1;
    localparam logic        AUTO_ENABLE_RESET  = 1'h1;
    localparam logic        PAIR_STATE_RESET   = 1'h0;
    localparam logic [3:0]  SEED_RESET         = 4'h0;
    localparam logic [3:0]  DEFAULT_SEED       = 4'h5;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SYS_CLK_MHZ    = 200;
    localparam int SLOT_TIME_US   = 60;
    localparam int BLINK_HALF_MS  = 40;
    localparam int SLOT_CYCLES    = SLOT_TIME_US * SYS_CLK_MHZ;
    localparam int BLINK_CYCLES   = BLINK_HALF_MS * 1000 * SYS_CLK_MHZ;
endpackage

//--- sim/link_partner_model.sv
// far-end transceiver model that reports signal once pairing suits it
`timescale 1ns/1ps
module link_partner_model (
    input  wire logic i_sys_clk,
    input  wire logic i_reset,
    input  wire logic i_detect_enable,
    input  wire logic i_wants_crossed,
    input  wire logic i_pair_crossover_state,
    output logic      o_signal_detect
);
    logic [1:0] match_reg; // edges the pairing has matched
    // detect only after three matching edges, like a real receiver locking
    always_ff @(posedge i_sys_clk) begin
        if (i_reset || !i_detect_enable) begin
            match_reg <= 2'h0;
        end else if (i_pair_crossover_state != i_wants_crossed) begin
            match_reg <= 2'h0;
        end else if (match_reg != 2'h3) begin
            match_reg <= match_reg + 2'h1;
        end
    end
    assign o_signal_detect = (match_reg == 2'h3);
endmodule

//--- sim/testbench.sv
// register-level bench for the led select and crossover block
`timescale 1ns/1ps
module testbench;
    logic        i_sys_clk = 1'b0, i_reset = 1'b1, sd;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready;
    logic        bvalid, arready, rvalid, led0, led1, pair;
    logic [1:0]  bresp, rresp, r;
    logic [5:0]  cond = 6'h00;   // link, rx, tx, collision, 100, duplex
    logic [1:0]  aneg = 2'h0;    // local, partner
    logic        det_en = 1'b0, want_x = 1'b0;
    logic [31:0] d;
    int          mismatches = 0, tests_run = 0;
    logic [5:0]  pats [3] = '{6'h32, 6'h0D, 6'h20};
    logic [7:0]  xo_v [4] = '{8'hC0, 8'hCB, 8'h40, 8'hC0};
    logic [1:0]  perm [4] = '{2'h2, 2'h2, 2'h1, 2'h1};
    logic [1:0]  ex   [4] = '{2'h2, 2'h3, 2'h0, 2'h2};
    always #2.5 i_sys_clk = ~i_sys_clk;
    phy_led_select_and_crossover_ctrl #(.SLOT_CYCLES(8), .BLINK_CYCLES(4))
    phy_led_select_and_crossover_ctrl_i (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_link_good(cond[5]), .i_rx_activity(cond[4]),
        .i_tx_activity(cond[3]), .i_collision(cond[2]),
        .i_speed_100(cond[1]), .i_full_duplex(cond[0]),
        .i_local_aneg_enable(aneg[1]), .i_partner_aneg_seen(aneg[0]),
        .i_signal_detect(sd), .o_first_led(led0), .o_second_led(led1),
        .o_pair_crossover_state(pair));
    link_partner_model link_partner_model_i (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_detect_enable(det_en),
        .i_wants_crossed(want_x), .i_pair_crossover_state(pair),
        .o_signal_detect(sd));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // one write; offers address and data together, waits for response
    task automatic axi_write(input logic [31:0] a, v, input logic [3:0] s);
        logic aw_ok, w_ok, aw_t, w_t, b_ok;
        aw_ok = 1'b0; w_ok = 1'b0; b_ok = 1'b0;
        awaddr <= a; wdata <= v; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(negedge i_sys_clk);
            aw_t = awvalid && awready; w_t = wvalid && wready;
            @(posedge i_sys_clk);
            if (aw_t) begin awvalid <= 1'b0; aw_ok = 1'b1; end
            if (w_t) begin wvalid <= 1'b0; w_ok = 1'b1; end
        end
        while (!b_ok) begin
            @(negedge i_sys_clk); b_ok = bvalid; r = bresp;
            @(posedge i_sys_clk);
        end
    endtask
    task automatic wr(input logic [31:0] a, v);
        axi_write(a, v, 4'h3);
    endtask
    // one read; holds rready until rvalid, keeps data and response
    task automatic rd(input logic [31:0] a);
        logic ok;
        ok = 1'b0; araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!ok) begin
            @(negedge i_sys_clk); ok = arready; @(posedge i_sys_clk);
        end
        arvalid <= 1'b0; ok = 1'b0;
        while (!ok) begin
            @(negedge i_sys_clk); ok = rvalid; d = rdata; r = rresp;
            @(posedge i_sys_clk);
        end
    endtask
    // expected lamp level for a selector code and condition set
    function automatic logic exp_led(input logic [3:0] c, input logic [5:0] v);
        case (c)
            4'h0, 4'h8: return v[5];
            4'h1:       return v[4] | v[3];
            4'h2:       return v[3];
            4'h3:       return v[4];
            4'h4:       return v[2];
            4'h5:       return v[1];
            4'h6:       return !v[1];
            4'h7:       return v[0];
            default:    return 1'b0;
        endcase
    endfunction
    task automatic complete_run;
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rd(phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR);
        check("led reset", d, 32'h0000_0010);
        rd(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR);
        check("xo reset", d, 32'h0000_00C0);
        rd(32'h0000_0008);
        check("bad read", {d[29:0], r}, {30'h0, 2'h2});
        axi_write(32'h0000_0008, 32'hFF, 4'hF);
        check("bad write", r, 32'h2);
        axi_write(phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR, 32'hABCD, 4'h2);
        rd(phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR);
        check("led lane", d, 32'h0000_AB10);
        // every selector code under three condition sets
        for (int p = 0; p < 3; p++) begin
            cond <= pats[p];
            for (int c = 0; c < 16; c++) begin
                wr(phy_led_xo_pkg::LED_SOURCE_SELECT_ADDR, {~c[3:0], c[3:0]});
                repeat (2) @(posedge i_sys_clk);
                // link with activity: lamp must flip each blink half period
                if (c == 8 && pats[p][5] && (pats[p][4] | pats[p][3])) begin
                    d[0] = led0;
                    repeat (4) @(posedge i_sys_clk);
                    check("blink0", led0, !d[0]);
                end else begin
                    check("led0", led0, exp_led(c, pats[p]));
                end
                if (!(c == 7 && pats[p][5] && (pats[p][4] | pats[p][3])))
                    check("led1", led1, exp_led(~c, pats[p]));
            end
        end
        // pairing at attempts four, five and nine per seed and permission
        for (int k = 0; k < 4; k++) begin
            aneg <= perm[k];
            wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'h80);
            wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, xo_v[k]);
            repeat (35) @(posedge i_sys_clk);
            check("attempt4", pair, ex[k][1]);
            repeat (8) @(posedge i_sys_clk);
            check("attempt5", pair, ex[k][0]);
            repeat (32) @(posedge i_sys_clk);
            check("attempt9", pair, xo_v[k][3]);
        end
        // partner locks on crossed pairs, then forced settings
        aneg <= 2'h2; det_en <= 1'b1; want_x <= 1'b1;
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'h80);
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'hC0);
        repeat (150) @(posedge i_sys_clk);
        rd(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR);
        check("done", d, 32'hF0);
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'hC0);
        rd(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR);
        check("pair locked", d, 32'hF0);
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'h80);
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'hA0);
        rd(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR);
        check("forced x", {d[30:0], pair}, 33'h141);
        wr(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR, 32'h8A);
        rd(phy_led_xo_pkg::CROSSOVER_CONTROL_ADDR);
        check("forced mdi", {d[30:0], pair}, 33'h114);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        mismatches++;
        complete_run;
    end
endmodule
